// *** core/fll_status_pkg.sv ***
// constants for the clock unit status block
// assumes a 32-bit axi4-lite register bus and one bus clock
package fll_status_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] status_off = 8'h04; // clock_unit_status
	localparam logic [7:0] irq_en_off = 8'h08; // lock_loss_irq_en
	localparam logic [7:0] irq_stat_off = 8'h0c; // sticky event status
	localparam logic [7:0] irq_mask_off = 8'h10; // event mask
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int loss_sticky_bit = 7;
	localparam int lock_bit = 6;
	localparam int refst_bit = 4;
	localparam int mode_lsb = 2;
	localparam int ev_loss_bit = 0;
	localparam int ev_lock_bit = 1;
	// reset values
	localparam logic [7:0] status_rst = 8'h00;
	localparam logic [1:0] mask_rst = 2'h0;
	// clock mode codes
	localparam logic [1:0] mode_fll = 2'h0;
	localparam logic [1:0] mode_byp_int = 2'h1;
	localparam logic [1:0] mode_byp_ext = 2'h2;
	// bus responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage : fll_status_pkg

// *** core/fll_clock_status.sv ***
// clock unit status register block with axi4-lite slave
// assumes lock detector and synchronised selects come from the clock core
`timescale 1ns/1ps
module fll_clock_status (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fll_enable, // loop is running
	input wire logic lock_detect_en, // lock detection requested
	input wire logic fll_in_lock, // detector: within entry tolerance
	input wire logic fll_out_tol, // detector: outside exit tolerance
	input wire logic ref_source_select, // synchronised select
	input wire logic [1:0] clock_source_select, // synchronised select
	input wire logic [2:0] ref_divider,
	input wire logic [7:0] trim,
	input wire logic stop_entry, // one-cycle stop entry pulse
	output logic irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {
		wr_idle = 3'b001,
		wr_resp = 3'b010,
		wr_hold = 3'b100
	} wr_state_t;
	typedef struct packed {
		wr_state_t wst; // write channel state
		logic aw_got; // address taken
		logic w_got; // data taken
		logic [7:0] aw_addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic lock_loss_sticky; // sticky loss of lock
		logic lock; // current lock
		logic refst; // reference source status
		logic [1:0] mode; // clock mode status
		logic lock_loss_irq_en; // loss irq enable
		logic [1:0] ev_stat; // sticky events
		logic [1:0] ev_mask; // event mask
		logic irq;
		logic ref_p; // previous ref select
		logic [2:0] div_p; // previous divider
		logic [7:0] trim_p; // previous trim
	} state_t;
	state_t q, d;
	// combinational helpers
	logic det_on, loss_ev, lock_ev, wr_go, wr_ok, reg_change;
	logic [31:0] rd_val;
	logic rd_ok;
	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		// detection is forced off while the loop is off
		det_on = lock_detect_en && fll_enable;
		// a change that invalidates lock while locked
		reg_change = (ref_source_select != q.ref_p) ||
			(ref_divider != q.div_p) ||
			((trim != q.trim_p) && ((q.mode == fll_status_pkg::mode_fll &&
			ref_source_select) ||
			q.mode == fll_status_pkg::mode_byp_int));
		loss_ev = det_on && q.lock && fll_out_tol;
		lock_ev = det_on && !q.lock && fll_in_lock &&
			!reg_change && !stop_entry;
		d.ref_p = ref_source_select;
		d.div_p = ref_divider;
		d.trim_p = trim;
		// lock indication
		if (!det_on || loss_ev || stop_entry || (q.lock && reg_change)) begin
			d.lock = 1'b0;
		end else if (lock_ev) begin
			d.lock = 1'b1;
		end
		// status follows only the synchronised selects
		d.refst = ref_source_select;
		d.mode = clock_source_select;
		// write channel
		d.awready = 1'b0;
		d.wready = 1'b0;
		if (s_axi_awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		wr_go = 1'b0;
		wr_ok = 1'b1;
		case (q.wst)
			wr_idle: begin
				d.awready = !d.aw_got && !(s_axi_awvalid && q.awready);
				d.wready = !d.w_got && !(s_axi_wvalid && q.wready);
				if (q.aw_got && q.w_got) begin
					d.wst = wr_resp;
				end
			end
			wr_resp: begin
				wr_go = 1'b1;
				d.bvalid = 1'b1;
				d.wst = wr_hold;
				d.aw_got = 1'b0;
				d.w_got = 1'b0;
			end
			wr_hold: begin
				if (s_axi_bready) begin
					d.bvalid = 1'b0;
					d.wst = wr_idle;
				end
			end
			default: begin
				d.wst = wr_idle;
			end
		endcase
		case (q.aw_addr)
			fll_status_pkg::status_off,
			fll_status_pkg::irq_en_off,
			fll_status_pkg::irq_stat_off,
			fll_status_pkg::irq_mask_off: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
		if (wr_go) begin
			d.bresp = wr_ok ? fll_status_pkg::resp_okay :
				fll_status_pkg::resp_slverr;
		end
		// sticky flags: clear by writing one, set wins over clear
		// only the sticky bit of the status word is writable
		if (wr_go && q.wstrb[0]) begin
			if (q.aw_addr == fll_status_pkg::status_off &&
				q.wdata[fll_status_pkg::loss_sticky_bit]) begin
				d.lock_loss_sticky = 1'b0;
			end
			// loss request enable
			if (q.aw_addr == fll_status_pkg::irq_en_off) begin
				d.lock_loss_irq_en = q.wdata[0];
			end
			if (q.aw_addr == fll_status_pkg::irq_stat_off) begin
				d.ev_stat = q.ev_stat & ~q.wdata[1:0];
			end
			if (q.aw_addr == fll_status_pkg::irq_mask_off) begin
				d.ev_mask = q.wdata[1:0];
			end
		end
		if (loss_ev) begin
			d.lock_loss_sticky = 1'b1;
			d.ev_stat[fll_status_pkg::ev_loss_bit] = 1'b1;
		end
		if (lock_ev) begin
			d.ev_stat[fll_status_pkg::ev_lock_bit] = 1'b1;
		end
		// loss request gated by its enable, events by the mask
		d.irq = (d.lock_loss_sticky && d.lock_loss_irq_en) ||
			|(d.ev_stat & d.ev_mask);
		// read channel
		rd_val = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			fll_status_pkg::status_off: begin
				rd_val[fll_status_pkg::loss_sticky_bit] = q.lock_loss_sticky;
				rd_val[fll_status_pkg::lock_bit] = q.lock;
				rd_val[fll_status_pkg::refst_bit] = q.refst;
				rd_val[fll_status_pkg::mode_lsb +: 2] = q.mode;
			end
			fll_status_pkg::irq_en_off: rd_val[0] = q.lock_loss_irq_en;
			fll_status_pkg::irq_stat_off: rd_val[1:0] = q.ev_stat;
			fll_status_pkg::irq_mask_off: rd_val[1:0] = q.ev_mask;
			default: rd_ok = 1'b0;
		endcase
		d.arready = 1'b0;
		if (q.rvalid) begin
			if (s_axi_rready) begin
				d.rvalid = 1'b0;
			end
		end else if (q.arready && s_axi_arvalid) begin
			d.rvalid = 1'b1;
			d.rdata = rd_val;
			d.rresp = rd_ok ? fll_status_pkg::resp_okay :
				fll_status_pkg::resp_slverr;
		end else begin
			d.arready = 1'b1;
		end
	end
	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.wst <= wr_idle;
			q.ev_mask <= fll_status_pkg::mask_rst;
		end else begin
			q <= d;
		end
	end
	// outputs straight from flops
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign irq = q.irq;
	// ----------------------------------------
	// assertions: sticky loss and interrupt
	// ----------------------------------------
	// loss while locked and detecting sets the sticky flag
	loss_sets_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(fll_enable && lock_detect_en && q.lock && fll_out_tol)
		|=> q.lock_loss_sticky)
		else $error("loss did not set sticky");
	// enabled sticky loss must hold the request up
	irq_gate_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(q.lock_loss_sticky && q.lock_loss_irq_en)
		|-> irq)
		else $error("irq missing");
	// no enable and no event means no request
	irq_off_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(!q.lock_loss_irq_en && q.ev_stat == 2'h0)
		|-> !irq)
		else $error("irq without cause");
	// a one written to the sticky bit clears it
	clear_one_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(q.wst == wr_resp && q.wstrb[0] && !loss_ev &&
		q.aw_addr == fll_status_pkg::status_off &&
		q.wdata[fll_status_pkg::loss_sticky_bit])
		|=> !q.lock_loss_sticky)
		else $error("one write kept sticky");
	// a zero written to the sticky bit changes nothing
	zero_keeps_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(q.wst == wr_resp && q.lock_loss_sticky &&
		!q.wdata[fll_status_pkg::loss_sticky_bit])
		|=> q.lock_loss_sticky)
		else $error("zero write cleared sticky");
	// ----------------------------------------
	// assertions: lock and status fields
	// ----------------------------------------
	// a qualified lock event raises the indication
	lock_set_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		lock_ev
		|=> q.lock)
		else $error("lock not set");
	// loop off forces detection and lock off
	lock_off_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!fll_enable
		|=> !q.lock)
		else $error("lock while off");
	// a control change while locked drops the lock
	change_clears_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(q.lock && reg_change)
		|=> !q.lock)
		else $error("change kept lock");
	// stop entry drops the lock
	stop_clears_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		stop_entry
		|=> !q.lock)
		else $error("stop kept lock");
	// lock only rises with the detector agreeing
	hw_only_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$rose(q.lock)
		|-> $past(fll_in_lock))
		else $error("lock rose without detector");
	// reference status trails its select by one flop
	ref_lag_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		1'b1
		|=> q.refst == $past(ref_source_select))
		else $error("ref status wrong");
	// mode status trails its select by one flop
	mode_lag_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		1'b1
		|=> q.mode == $past(clock_source_select))
		else $error("mode status wrong");
	// bits 31:8 and bit 5 of every read word stay zero
	rsvd_zero_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid
		|-> (s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[5]))
		else $error("reserved bit set");
	// ----------------------------------------
	// assertions: bus handshakes
	// ----------------------------------------
	// write response stands until taken
	bvalid_hold_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready)
		|=> s_axi_bvalid)
		else $error("write response dropped");
	// read data stand until taken
	rvalid_hold_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready)
		|=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read data dropped");
	// write state stays one-hot
	wst_onehot_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		1'b1
		|-> $onehot(q.wst))
		else $error("write state corrupt");
	// ----------------------------------------
	// covers
	// ----------------------------------------
	// sticky loss raising the request
	loss_c: cover property (@(posedge aclk) q.lock_loss_sticky && irq);
	// lock gained
	lock_c: cover property (@(posedge aclk) !q.lock ##1 q.lock);
	// write answered and taken
	wr_c: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
	// read answered and taken
	rd_c: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
	// stop entry while locked
	stop_c: cover property (@(posedge aclk) stop_entry && q.lock);
endmodule : fll_clock_status

// *** tb/tb_top.sv ***
// self-checking bench for the clock unit status block
// assumes fll_status_pkg and fll_clock_status are compiled first
`timescale 1ns/1ps
module tb_top;
	// ----
	// signals and ordinary cases
	// ----
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rsp, brs;
	logic [31:0] rdata, got;
	logic en = 1'b0, det = 1'b0, inl = 1'b0, otol = 1'b0, rsel = 1'b0;
	logic stop = 1'b0;
	logic [1:0] csel = 2'h0;
	logic [2:0] div_sel = 3'h0;
	logic [7:0] trim = 8'h00;
	int bad_count = 0, checks = 0, cyc = 0, i;
	// one row: inputs, address read, expected data and response
	typedef struct packed {
		logic en, det, inl, rs;
		logic [1:0] cs;
		logic [7:0] a;
		logic [31:0] d;
		logic [1:0] r;
	} row_t;
	row_t rows [7] = '{
		'{1'h0,1'h0,1'h0,1'h0,2'h0,8'h04,32'h00,2'h0},
		'{1'h0,1'h0,1'h0,1'h1,2'h1,8'h04,32'h14,2'h0},
		'{1'h0,1'h0,1'h0,1'h0,2'h2,8'h04,32'h08,2'h0},
		'{1'h1,1'h0,1'h1,1'h1,2'h0,8'h04,32'h10,2'h0},
		'{1'h0,1'h1,1'h1,1'h0,2'h0,8'h04,32'h00,2'h0},
		'{1'h0,1'h0,1'h0,1'h0,2'h0,8'h20,32'h00,2'h2},
		'{1'h1,1'h1,1'h1,1'h0,2'h0,8'h04,32'h40,2'h0}};
	// 200 MHz bus clock
	always #2.5 aclk = ~aclk;
	fll_clock_status i_fll_clock_status (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .fll_enable(en),
		.lock_detect_en(det), .fll_in_lock(inl), .fll_out_tol(otol),
		.ref_source_select(rsel), .clock_source_select(csel),
		.ref_divider(div_sel), .trim(trim), .stop_entry(stop), .irq(irq));
	// ----
	// tasks
	// ----
	task wrap_up;
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// compare and count
	task chk_v(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_v
	// bus write; handshakes judged on settled values before each edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		bh = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bh) begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			brs = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	// bus read, then compare data and response
	task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		logic ah, rh;
		rh = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rh) begin
			@(negedge aclk);
			ah = arvalid & arready;
			rh = rvalid;
			got = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge aclk);
		chk_v(got, e);
		chk_v({30'h0, rsp}, {30'h0, r});
	endtask : rdc
	// interrupt level on a settled clock phase
	task ck_irq(input logic e);
		@(negedge aclk);
		chk_v({31'h0, irq}, {31'h0, e});
		@(posedge aclk);
	endtask : ck_irq
	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			bad_count++;
			wrap_up();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		ck_irq(1'b0);
		for (i = 0; i < 7; i++) begin
			{en, det, inl, rsel, csel} <= {rows[i].en, rows[i].det,
				rows[i].inl, rows[i].rs, rows[i].cs};
			repeat (4) @(posedge aclk);
			rdc(rows[i].a, rows[i].d, rows[i].r);
		end
		// loss of lock with its interrupt enabled
		wr(8'h08, 32'h1);
		rdc(8'h08, 32'h1, 2'h0);
		otol <= 1'b1;
		inl <= 1'b0;
		repeat (4) @(posedge aclk);
		otol <= 1'b0;
		repeat (4) @(posedge aclk);
		rdc(8'h04, 32'h80, 2'h0);
		ck_irq(1'b1);
		wr(8'h04, 32'h0);
		rdc(8'h04, 32'h80, 2'h0);
		wr(8'h08, 32'h0);
		ck_irq(1'b0);
		wr(8'h04, 32'hff);
		chk_v({30'h0, brs}, 32'h0);
		rdc(8'h04, 32'h00, 2'h0);
		wr(8'h20, 32'hff);
		chk_v({30'h0, brs}, 32'h2);
		rdc(8'h04, 32'h00, 2'h0);
		// masked event path: lock-gained event
		wr(8'h10, 32'h2);
		ck_irq(1'b1);
		wr(8'h0c, 32'h3);
		ck_irq(1'b0);
		// lock cleared by divider, stop entry, internal trim change
		for (i = 0; i < 3; i++) begin
			rsel <= (i == 2);
			inl <= 1'b1;
			repeat (4) @(posedge aclk);
			rdc(8'h04, (i == 2) ? 32'h50 : 32'h40, 2'h0);
			case (i)
				0: div_sel <= 3'h5;
				1: stop <= 1'b1;
				default: trim <= 8'h3c;
			endcase
			inl <= 1'b0;
			@(posedge aclk);
			stop <= 1'b0;
			repeat (3) @(posedge aclk);
			rdc(8'h04, (i == 2) ? 32'h10 : 32'h00, 2'h0);
		end
		// sticky set, then a mid-run reset clears it
		inl <= 1'b1;
		repeat (4) @(posedge aclk);
		otol <= 1'b1;
		inl <= 1'b0;
		repeat (4) @(posedge aclk);
		otol <= 1'b0;
		repeat (4) @(posedge aclk);
		rdc(8'h04, 32'h90, 2'h0);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(8'h04, 32'h10, 2'h0);
		rdc(8'h08, 32'h0, 2'h0);
		ck_irq(1'b0);
		wrap_up();
	end
endmodule : tb_top
